// ---- flash_host_pkg.sv ----
/*
  Shared constants and types for the flash bypass-mode host controller:
  command codes, status bit positions, register offsets, pin bundles and
  strobe timing. Assumes a 16-bit NOR flash on a 100 MHz controller clock.
*/
package flash_host_pkg;

  // ==========================================================================
  // widths and clock
  localparam int FA_W          = 24;
  localparam int DQ_W          = 16;
  localparam int CLK_PERIOD_NS = 10;
  localparam int SYNC_STAGES   = 2;

  // ==========================================================================
  // strobe timing in ns and the derived clock counts (least times round up)
  localparam int T_SETUP_NS = 20;
  localparam int T_WP_NS    = 40;
  localparam int T_WPH_NS   = 30;
  localparam int T_ACC_NS   = 110;
  localparam int T_OEH_NS   = 20;

  function automatic logic [7:0] ns_to_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return 8'(c);
  endfunction : ns_to_cyc

  localparam logic [7:0] SETUP_CNT = ns_to_cyc(T_SETUP_NS);
  localparam logic [7:0] WP_CNT    = ns_to_cyc(T_WP_NS);
  localparam logic [7:0] WPH_CNT   = ns_to_cyc(T_WPH_NS);
  localparam logic [7:0] ACC_CNT   = 8'(ns_to_cyc(T_ACC_NS) + SYNC_STAGES);
  localparam logic [7:0] OEH_CNT   = ns_to_cyc(T_OEH_NS);

  // ==========================================================================
  // flash command cycles
  localparam logic [FA_W-1:0] UNLOCK_ADDR1 = 24'h000555;
  localparam logic [FA_W-1:0] UNLOCK_ADDR2 = 24'h0002AA;
  localparam logic [FA_W-1:0] ANY_ADDR     = 24'h000000;
  localparam logic [DQ_W-1:0] UNLOCK_DATA1 = 16'h00AA;
  localparam logic [DQ_W-1:0] UNLOCK_DATA2 = 16'h0055;
  localparam logic [DQ_W-1:0] BYPASS_ENTRY = 16'h0020;
  localparam logic [DQ_W-1:0] BYPASS_PROG  = 16'h00A0;
  localparam logic [DQ_W-1:0] BYPASS_EXIT1 = 16'h0090;
  localparam logic [DQ_W-1:0] BYPASS_EXIT2 = 16'h0000;

  // status bit positions on the flash data bus
  localparam int DATA_POLLING_BIT  = 7;
  localparam int FIRST_TOGGLE_BIT  = 6;
  localparam int TIMING_LIMIT_FLAG = 5;
  localparam int SECTOR_TOGGLE_BIT = 2;
  localparam int BUFFER_ABORT_FLAG = 1;

  // ==========================================================================
  // software operation codes
  localparam logic [2:0] OP_ENTER  = 3'h1;
  localparam logic [2:0] OP_PROG   = 3'h2;
  localparam logic [2:0] OP_EXIT   = 3'h3;
  localparam logic [2:0] OP_READ   = 3'h4;
  localparam logic [2:0] OP_TOGGLE = 3'h5;

  // ==========================================================================
  // register map (byte offsets) and status fields
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0C;
  localparam logic [7:0] REG_RDATA  = 8'h10;

  localparam int ST_BUSY    = 0;
  localparam int ST_BYPASS  = 1;
  localparam int ST_DONE    = 2;
  localparam int ST_FAIL    = 3;
  localparam int ST_REFUSED = 4;
  localparam int ST_ABORT   = 5;
  localparam int ST_SECTOR  = 6;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic            wr;
    logic [FA_W-1:0] addr;
    logic [DQ_W-1:0] data;
  } flash_req_t;

  typedef struct packed {
    logic            ce_n;
    logic            oe_n;
    logic            we_n;
    logic            dq_oe_n;
    logic [FA_W-1:0] addr;
    logic [DQ_W-1:0] dq_out;
  } flash_pins_t;

endpackage : flash_host_pkg

// ---- flash_cycle.sv ----
/*
  One asynchronous flash bus cycle (write or read) timed in clock counts.
  Assumes requests arrive only while idle; dq_in is asynchronous.
*/
`timescale 1ns/1ns
module flash_cycle (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           arst_n,
  input  wire logic                           clk_en,
  // request side
  input  wire logic                           req_valid,
  input  wire flash_host_pkg::flash_req_t     req,
  output logic                                done_ff,
  output logic [flash_host_pkg::DQ_W-1:0]     rdata_ff,
  // flash pins
  input  wire logic [flash_host_pkg::DQ_W-1:0] dq_in,
  output flash_host_pkg::flash_pins_t         pins_ff
);

  typedef enum logic [3:0] {
    CY_IDLE    = 4'b0001,
    CY_SETUP   = 4'b0010,
    CY_STROBE  = 4'b0100,
    CY_RECOVER = 4'b1000
  } cyc_state_t;

  cyc_state_t                      state_ff, nxt_state;
  logic [7:0]                      cnt_ff, nxt_cnt;
  logic                            nxt_done;
  logic [flash_host_pkg::DQ_W-1:0] nxt_rdata, dq_meta_ff, dq_sync_ff;
  flash_host_pkg::flash_req_t      req_ff, nxt_req;
  flash_host_pkg::flash_pins_t     nxt_pins;
  wire                             last = (cnt_ff == 8'h01);

  // ==========================================================================
  // cycle sequencing
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_done  = 1'b0;
    nxt_rdata = rdata_ff;
    nxt_req   = req_ff;
    unique case (state_ff)
      CY_IDLE: if (req_valid) begin
        nxt_req   = req;
        nxt_state = CY_SETUP;
        nxt_cnt   = req.wr ? flash_host_pkg::SETUP_CNT
                           : flash_host_pkg::ACC_CNT;
      end
      CY_SETUP: if (last) begin
        if (req_ff.wr) begin
          nxt_state = CY_STROBE;
          nxt_cnt   = flash_host_pkg::WP_CNT;
        end else begin
          nxt_rdata = dq_sync_ff;       // sampled after access + sync
          nxt_state = CY_RECOVER;
          nxt_cnt   = flash_host_pkg::OEH_CNT;
        end
      end else begin
        nxt_cnt = cnt_ff - 8'h01;
      end
      CY_STROBE: if (last) begin
        nxt_state = CY_RECOVER;
        nxt_cnt   = flash_host_pkg::WPH_CNT;
      end else begin
        nxt_cnt = cnt_ff - 8'h01;
      end
      CY_RECOVER: if (last) begin
        nxt_state = CY_IDLE;
        nxt_done  = 1'b1;
      end else begin
        nxt_cnt = cnt_ff - 8'h01;
      end
    endcase
  end

  // pin levels follow the next state; reads release ce and oe between
  // accesses so each status read is a separate access
  assign nxt_pins.ce_n    = (nxt_state == CY_IDLE) |
                            (!nxt_req.wr & (nxt_state == CY_RECOVER));
  assign nxt_pins.oe_n    = nxt_req.wr | (nxt_state != CY_SETUP);
  assign nxt_pins.we_n    = (nxt_state != CY_STROBE);
  assign nxt_pins.dq_oe_n = !(nxt_req.wr && (nxt_state != CY_IDLE));
  assign nxt_pins.addr    = nxt_req.addr;
  assign nxt_pins.dq_out  = nxt_req.data;

  // state, pins and input synchroniser
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff   <= CY_IDLE;
      cnt_ff     <= 8'h00;
      done_ff    <= 1'b0;
      rdata_ff   <= 16'h0000;
      req_ff     <= '0;
      pins_ff    <= {4'hF, 24'h000000, 16'h0000};
      dq_meta_ff <= 16'h0000;
      dq_sync_ff <= 16'h0000;
    end else if (clk_en) begin
      state_ff   <= nxt_state;
      cnt_ff     <= nxt_cnt;
      done_ff    <= nxt_done;
      rdata_ff   <= nxt_rdata;
      req_ff     <= nxt_req;
      pins_ff    <= nxt_pins;
      dq_meta_ff <= dq_in;
      dq_sync_ff <= dq_meta_ff;
    end
  end

endmodule : flash_cycle

// ---- flash_host.sv ----
/*
  Host controller that drives a NOR flash through unlock-bypass entry,
  bypass word programming, bypass exit, plain reads and status polling.
  Software reaches it over APB; the flash pins are asynchronous.
*/
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module flash_host (
  // clock and reset
  input  wire logic                           sys_clk,
  input  wire logic                           arst_n,
  input  wire logic                           clk_en,
  // apb slave
  input  wire logic                           psel,
  input  wire logic                           penable,
  input  wire logic                           pwrite,
  input  wire logic [7:0]                     paddr,
  input  wire logic [31:0]                    pwdata,
  output logic [31:0]                         prdata_ff,
  output logic                                pready_ff,
  output logic                                pslverr_ff,
  // flash pins
  input  wire logic [flash_host_pkg::DQ_W-1:0] dq_in,
  output flash_host_pkg::flash_pins_t         pins_ff
);

  typedef enum logic [3:0] {
    M_IDLE  = 4'b0001,
    M_ISSUE = 4'b0010,
    M_POLL  = 4'b0100,
    M_FINAL = 4'b1000
  } main_state_t;

  main_state_t                     state_ff, nxt_state;
  logic [2:0]                      op_ff;
  logic [1:0]                      step_ff;
  logic [flash_host_pkg::FA_W-1:0] addr_ff;
  logic [flash_host_pkg::DQ_W-1:0] wdata_ff, rdata_ff;
  logic                            bypass_ff, done_ff, fail_ff;
  logic                            refused_ff, abort_ff, sector_ff;
  logic                            first_ff, recheck_ff, prev_tog_ff;
  logic                            cyc_req_ff;
  flash_host_pkg::flash_req_t      cyc_cmd_ff;
  logic                            cyc_done;
  logic [flash_host_pkg::DQ_W-1:0] cyc_rdata;

  // ==========================================================================
  // bus cycle engine
  flash_cycle u_cycle (
    .sys_clk   (sys_clk),
    .arst_n    (arst_n),
    .clk_en    (clk_en),
    .req_valid (cyc_req_ff),
    .req       (cyc_cmd_ff),
    .done_ff   (cyc_done),
    .rdata_ff  (cyc_rdata),
    .dq_in     (dq_in),
    .pins_ff   (pins_ff)
  );

  // ==========================================================================
  // apb decode: zero-wait answer, pready high in every access phase
  wire apb_setup  = psel & ~penable;
  wire apb_wr     = psel & penable & pwrite & pready_ff;
  wire hit_cmd    = (paddr == flash_host_pkg::REG_CMD);
  wire hit_addr   = (paddr == flash_host_pkg::REG_ADDR);
  wire hit_wdata  = (paddr == flash_host_pkg::REG_WDATA);
  wire hit_status = (paddr == flash_host_pkg::REG_STATUS);
  wire hit_rdata  = (paddr == flash_host_pkg::REG_RDATA);
  wire mapped     = hit_cmd | hit_addr | hit_wdata | hit_status | hit_rdata;
  wire idle       = (state_ff == M_IDLE);

  wire [31:0] status_word = {25'h0, sector_ff, abort_ff, refused_ff,
                             fail_ff, done_ff, bypass_ff, ~idle};
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_addr   ? 32'(addr_ff) :
                       hit_wdata  ? {16'h0000, wdata_ff} :
                       hit_rdata  ? {16'h0000, rdata_ff} : 32'h00000000;

  // command acceptance: only orders legal in the current mode start
  wire [2:0] new_op  = pwdata[2:0];
  wire cmd_wr        = apb_wr & hit_cmd;
  wire op_legal      = (new_op == flash_host_pkg::OP_ENTER  & ~bypass_ff) |
                       (new_op == flash_host_pkg::OP_PROG   &  bypass_ff) |
                       (new_op == flash_host_pkg::OP_EXIT   &  bypass_ff) |
                       (new_op == flash_host_pkg::OP_READ)                |
                       (new_op == flash_host_pkg::OP_TOGGLE);
  wire start         = cmd_wr & idle & op_legal;
  wire refuse        = cmd_wr & ~start;

  // ==========================================================================
  // command steps: unlock entry, bypass program, bypass exit, read
  wire [1:0] last_step =
    (op_ff == flash_host_pkg::OP_ENTER) ? 2'd2 :
    (op_ff == flash_host_pkg::OP_PROG ||
     op_ff == flash_host_pkg::OP_EXIT)  ? 2'd1 : 2'd0;

  wire [1:0] nxt_step = step_ff + 2'd1;

  // status reads always go to the programmed or erasing address
  flash_host_pkg::flash_req_t poll_rd;
  assign poll_rd = '{wr: 1'b0, addr: addr_ff, data: 16'h0000};

  // first cycle of a newly accepted order, issued with start
  flash_host_pkg::flash_req_t first_req;
  always_comb begin
    first_req = poll_rd;
    unique case (new_op)
      flash_host_pkg::OP_ENTER:
        first_req = '{1'b1, flash_host_pkg::UNLOCK_ADDR1,
                      flash_host_pkg::UNLOCK_DATA1};
      flash_host_pkg::OP_PROG:
        first_req = '{1'b1, flash_host_pkg::ANY_ADDR,
                      flash_host_pkg::BYPASS_PROG};
      flash_host_pkg::OP_EXIT:
        first_req = '{1'b1, flash_host_pkg::ANY_ADDR,
                      flash_host_pkg::BYPASS_EXIT1};
      default: first_req = poll_rd;
    endcase
  end

  // follow-on cycles: the command for the step about to be issued
  flash_host_pkg::flash_req_t step_req;
  always_comb begin
    step_req = poll_rd;
    unique case (op_ff)
      flash_host_pkg::OP_ENTER: begin
        unique case (nxt_step)
          2'd1: step_req = '{1'b1, flash_host_pkg::UNLOCK_ADDR2,
                             flash_host_pkg::UNLOCK_DATA2};
          default: step_req = '{1'b1, flash_host_pkg::UNLOCK_ADDR1,
                                flash_host_pkg::BYPASS_ENTRY};
        endcase
      end
      flash_host_pkg::OP_PROG:
        step_req = '{1'b1, addr_ff, wdata_ff};
      flash_host_pkg::OP_EXIT:
        step_req = '{1'b1, flash_host_pkg::ANY_ADDR,
                     flash_host_pkg::BYPASS_EXIT2};
      default: step_req = poll_rd;
    endcase
  end

  // ==========================================================================
  // poll decisions on each returned status read
  wire rd_dp    = cyc_rdata[flash_host_pkg::DATA_POLLING_BIT];
  wire rd_tog   = cyc_rdata[flash_host_pkg::FIRST_TOGGLE_BIT];
  wire rd_limit = cyc_rdata[flash_host_pkg::TIMING_LIMIT_FLAG];
  wire rd_abort = cyc_rdata[flash_host_pkg::BUFFER_ABORT_FLAG];
  wire is_prog  = (op_ff == flash_host_pkg::OP_PROG);
  // polling bit equals written bit 7 once programming is over
  wire dp_match = (rd_dp == wdata_ff[flash_host_pkg::DATA_POLLING_BIT]);
  // toggle bit stopped between two separate reads means finished
  wire tog_stop = ~first_ff & (rd_tog == prev_tog_ff);
  wire finished = is_prog ? dp_match : tog_stop;
  // after the limit flag rose, one more check decides failure
  wire give_up  = recheck_ff | (is_prog & rd_abort);

  // ==========================================================================
  // main sequencer
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      M_IDLE:  if (start) nxt_state =
                 (new_op == flash_host_pkg::OP_TOGGLE) ? M_POLL : M_ISSUE;
      M_ISSUE: if (cyc_done && step_ff == last_step) nxt_state =
                 is_prog ? M_POLL : M_IDLE;
      M_POLL:  if (cyc_done && (finished || give_up)) nxt_state =
                 (finished ? M_FINAL : M_IDLE);
      M_FINAL: if (cyc_done) nxt_state = M_IDLE;
    endcase
  end

  // sequencer registers and the cycle request it issues
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff    <= M_IDLE;
      op_ff       <= 3'h0;
      step_ff     <= 2'd0;
      cyc_req_ff  <= 1'b0;
      cyc_cmd_ff  <= '0;
      first_ff    <= 1'b1;
      recheck_ff  <= 1'b0;
      prev_tog_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff   <= nxt_state;
      cyc_req_ff <= 1'b0;
      if (start) begin
        op_ff       <= new_op;
        step_ff     <= 2'd0;
        first_ff    <= 1'b1;
        recheck_ff  <= 1'b0;
        cyc_req_ff  <= 1'b1;
        cyc_cmd_ff  <= first_req;
      end else if (cyc_done && nxt_state != M_IDLE) begin
        // next write step, or another status read at the same address
        cyc_req_ff <= 1'b1;
        if (state_ff == M_ISSUE && step_ff != last_step) begin
          step_ff    <= nxt_step;
          cyc_cmd_ff <= step_req;
        end else begin
          cyc_cmd_ff <= poll_rd;
        end
        if (state_ff == M_POLL) begin
          first_ff    <= 1'b0;
          prev_tog_ff <= rd_tog;
          if (rd_limit) recheck_ff <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // software registers, mode and result flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      addr_ff    <= 24'h000000;
      wdata_ff   <= 16'h0000;
      rdata_ff   <= 16'h0000;
      bypass_ff  <= 1'b0;
      done_ff    <= 1'b0;
      fail_ff    <= 1'b0;
      refused_ff <= 1'b0;
      abort_ff   <= 1'b0;
      sector_ff  <= 1'b0;
    end else if (clk_en) begin
      if (apb_wr && hit_addr && idle) addr_ff <= pwdata[23:0];
      if (apb_wr && hit_wdata && idle) wdata_ff <= pwdata[15:0];
      if (start) begin
        done_ff    <= 1'b0;
        fail_ff    <= 1'b0;
        refused_ff <= 1'b0;
        abort_ff   <= 1'b0;
      end
      if (refuse) refused_ff <= 1'b1;
      if (cyc_done && state_ff == M_ISSUE && step_ff == last_step) begin
        if (op_ff == flash_host_pkg::OP_ENTER) bypass_ff <= 1'b1;
        if (op_ff == flash_host_pkg::OP_EXIT)  bypass_ff <= 1'b0;
        if (op_ff == flash_host_pkg::OP_READ)  rdata_ff  <= cyc_rdata;
        if (!is_prog) done_ff <= 1'b1;
      end
      if (cyc_done && state_ff == M_POLL) begin
        sector_ff <= cyc_rdata[flash_host_pkg::SECTOR_TOGGLE_BIT];
        if (!finished && give_up) begin
          fail_ff  <= 1'b1;
          abort_ff <= is_prog & rd_abort;
          done_ff  <= 1'b1;
        end
      end
      if (cyc_done && state_ff == M_FINAL) begin
        rdata_ff <= cyc_rdata;
        done_ff  <= 1'b1;
      end
    end
  end

  // apb answer registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else if (clk_en) begin
      pready_ff  <= apb_setup;
      pslverr_ff <= apb_setup & ~mapped;
      if (apb_setup) prdata_ff <= rd_mux;
    end
  end

endmodule : flash_host

// ---- flash_host_assertions.sv ----
/* checker for apb answers and flash strobe shape of flash_host
   assumes the bind at the foot attaches it to every flash_host */
`timescale 1ns/1ns
module flash_host_assertions (
  // clock and reset
  input wire logic                        sys_clk,
  input wire logic                        arst_n,
  // apb
  input wire logic                        psel,
  input wire logic                        penable,
  input wire logic [7:0]                  paddr,
  input wire logic                        pready_ff,
  input wire logic                        pslverr_ff,
  // flash pins
  input wire flash_host_pkg::flash_pins_t pins_ff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // write strobe steps
  sequence we_pulse; !pins_ff.we_n [*4]; endsequence
  sequence we_recover; pins_ff.we_n && !pins_ff.ce_n; endsequence
  // apb answers and strobe relations
  ready_after_setup_a: assert property (psel && !penable |=> pready_ff)
    else $error("no ready after setup");
  ready_one_cycle_a: assert property (pready_ff |=> !pready_ff)
    else $error("ready held too long");
  unmapped_error_a: assert property (psel && !penable && paddr > 8'h10
    |=> pslverr_ff && pready_ff) else $error("no error for unmapped");
  we_pulse_width_a: assert property ($fell(pins_ff.we_n) |-> we_pulse
    ##1 we_recover) else $error("bad write pulse");
  write_data_held_a: assert property (!pins_ff.we_n |->
    $stable(pins_ff.dq_out) && $stable(pins_ff.addr))
    else $error("write data moved");
  drive_in_write_a: assert property (!pins_ff.we_n |-> !pins_ff.dq_oe_n
    && !pins_ff.ce_n) else $error("strobe without drive");
  no_bus_fight_a: assert property (!pins_ff.oe_n |-> pins_ff.dq_oe_n
    && pins_ff.we_n) else $error("read while driving");
  read_gap_a: assert property ($rose(pins_ff.oe_n) |-> pins_ff.oe_n [*2])
    else $error("reads not separate");
endmodule : flash_host_assertions
bind flash_host flash_host_assertions chk (.sys_clk(sys_clk),
  .arst_n(arst_n), .psel(psel), .penable(penable), .paddr(paddr),
  .pready_ff(pready_ff), .pslverr_ff(pslverr_ff), .pins_ff(pins_ff));

// ---- flash_model.sv ----
/* behavioural flash device: bypass commands and status bits
   assumes the controller's pins; drives the data bus back */
`timescale 1ns/1ns
module flash_model (
  // controller pins
  input  wire flash_host_pkg::flash_pins_t pins,
  // data bus back
  output logic [15:0]                      dq
);
  logic [15:0] q_ff = 16'h0000, mem_d_ff = 16'h0000, d;
  logic [23:0] mem_a_ff = 24'h000000, a;
  logic [1:0]  st_ff = 2'h0;
  logic        byp_ff = 1'b0, set_ff = 1'b0, ex_ff = 1'b0, tog_ff = 1'b0;
  logic        lim_ff = 1'b0, abt_ff = 1'b0;
  int          busy_ff = 0;
  // ==========================================================================
  // command decode at the rising write strobe
  always @(posedge pins.we_n) begin
    a = pins.addr;
    d = pins.dq_out;
    if (!pins.ce_n && busy_ff == 0) begin
      if (!byp_ff) begin
        byp_ff = st_ff == 2'h2 && a == 24'h000555 && d == 16'h0020;
        st_ff = (st_ff == 2'h0 && a == 24'h000555 && d == 16'h00AA) ? 2'h1
              : (st_ff == 2'h1 && a == 24'h0002AA && d == 16'h0055) ? 2'h2
              : 2'h0;
      end else if (set_ff) begin
        mem_a_ff = a;
        mem_d_ff = d;
        // two fixed addresses fail: one by time limit, one by abort
        lim_ff = a == 24'h00F0F0;
        abt_ff = a == 24'h00F0F1;
        busy_ff = lim_ff ? 2 : abt_ff ? 1 : 3;
        set_ff = 1'b0;
      end else if (ex_ff) begin
        byp_ff = d != 16'h0000;
        ex_ff = 1'b0;
      end else begin
        set_ff = d == 16'h00A0;
        ex_ff = d == 16'h0090;
      end
    end
  end
  // status while busy, else array data, one value per read access
  always @(negedge pins.oe_n) begin
    if (!pins.ce_n && busy_ff != 0) begin
      tog_ff = ~tog_ff;
      q_ff = {8'h00, ~mem_d_ff[7], tog_ff, lim_ff, 3'h0, abt_ff, 1'b0};
      busy_ff = busy_ff - 1;
    end else if (!pins.ce_n) begin
      q_ff = pins.addr == mem_a_ff ? mem_d_ff : pins.addr[15:0] ^ 16'hA5A5;
    end
  end
  // released bus shows the inverse of the last value
  assign dq = (!pins.ce_n && !pins.oe_n) ? q_ff : ~q_ff;
endmodule : flash_model

// ---- tb.sv ----
/* self-checking bench for flash_host with a flash model
   assumes the design package and the flash_model file */
`timescale 1ns/1ns
module tb;
  logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h00000000, prdata, rd;
  logic [15:0] dq;
  flash_host_pkg::flash_pins_t pins;
  int miscompares = 0, checked = 0;
  // ==========================================================================
  // clock, design and device
  initial forever #5 sys_clk = ~sys_clk;
  flash_host dut (.sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata_ff(prdata), .pready_ff(pready),
    .pslverr_ff(pslverr), .dq_in(dq), .pins_ff(pins));
  flash_model mdl (.pins(pins), .dq(dq));
  task check(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task tally_and_finish;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  // one apb transfer, waits for ready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin miscompares++; tally_and_finish(); end
  endtask : apb
  // issue an operation and poll status until not busy
  task cmd(input logic [2:0] op, input logic [23:0] a, input logic [15:0] d);
    int n;
    apb(1'b1, flash_host_pkg::REG_ADDR, {8'h00, a});
    apb(1'b1, flash_host_pkg::REG_WDATA, {16'h0000, d});
    apb(1'b1, flash_host_pkg::REG_CMD, {29'h0, op});
    n = 0;
    do begin apb(1'b0, flash_host_pkg::REG_STATUS, 32'h0); n++; end
    while (rd[0] !== 1'b0 && n < 500);
    if (n >= 500) begin miscompares++; tally_and_finish(); end
  endtask : cmd
  // reset values and an unmapped place
  task t_regs;
    apb(1'b0, flash_host_pkg::REG_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, flash_host_pkg::REG_CMD, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    check({rd, 31'h0, er}, {32'h0, 32'h1});
  endtask : t_regs
  // program and exit outside bypass are refused
  task t_refuse;
    cmd(flash_host_pkg::OP_PROG, 24'h000100, 16'h0011);
    check(rd[5:0], 6'h10);
    cmd(flash_host_pkg::OP_EXIT, 24'h000000, 16'h0000);
    check(rd[5:0], 6'h10);
  endtask : t_refuse
  // enter, refused re-entry, two programs, reads, two failing programs, exit
  task t_bypass;
    cmd(flash_host_pkg::OP_ENTER, 24'h000000, 16'h0000);
    check({rd[5:0], 31'h0, mdl.byp_ff}, {6'h06, 32'h1});
    cmd(flash_host_pkg::OP_ENTER, 24'h000000, 16'h0000);
    check({rd[5:0], 31'h0, mdl.byp_ff}, {6'h16, 32'h1});
    for (int i = 0; i < 2; i++) begin
      cmd(flash_host_pkg::OP_PROG, 24'h00AB00 + i, 16'h00C3 ^ (i << 7));
      check(rd[5:0], 6'h06);
      apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
      check(rd, 32'h00C3 ^ (i << 7));
      check({mdl.mem_a_ff, mdl.mem_d_ff},
            {24'(24'h00AB00 + i), 16'(16'h00C3 ^ (i << 7))});
    end
    cmd(flash_host_pkg::OP_TOGGLE, 24'h00AB01, 16'h0000);
    apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
    check(rd, 32'h0043);
    cmd(flash_host_pkg::OP_READ, 24'h000010, 16'h0000);
    apb(1'b0, flash_host_pkg::REG_RDATA, 32'h0);
    check(rd, 32'hA5B5);
    cmd(flash_host_pkg::OP_PROG, 24'h00F0F0, 16'h0000);
    check(rd[5:0], 6'h0E);
    cmd(flash_host_pkg::OP_PROG, 24'h00F0F1, 16'h0000);
    check(rd[5:0], 6'h2E);
    cmd(flash_host_pkg::OP_EXIT, 24'h000000, 16'h0000);
    check({rd[5:0], 31'h0, mdl.byp_ff}, {6'h04, 32'h0});
  endtask : t_bypass
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_refuse();
    t_bypass();
    tally_and_finish();
  end
endmodule : tb
